// ==== design/ch3dc_pkg.sv ====
// Purpose: constants and field layouts for the channel three divider control block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   printed offsets are register indices, byte address is four times the index
package ch3dc_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W            = 12;
    localparam logic [9:0]  IDX_CYCLES        = 10'h199;
    localparam logic [9:0]  IDX_MODE          = 10'h19a;
    localparam logic [9:0]  IDX_ROUTING       = 10'h19b;
    localparam logic [9:0]  IDX_STATUS        = 10'h19c;
    localparam logic [ADDR_W-1:0] ADDR_CYCLES  = {IDX_CYCLES, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MODE    = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ROUTING = {IDX_ROUTING, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic       bypass;
        logic       ignore_sync;
        logic       force_high;
        logic       start_high;
        logic [3:0] phase;
    } ch3dc_mode_s;

    typedef struct packed {
        logic [4:0] unused;
        logic       power_down;
        logic       direct;
        logic       dcc_disable;
    } ch3dc_routing_s;

    typedef struct packed {
        logic [3:0] low;
        logic [3:0] high;
    } ch3dc_cycles_s;

    typedef struct packed {
        logic       osc_level;
        logic       ext_level;
        logic [1:0] src_sel;
    } ch3dc_source_s;

    // ------------------------------------------------------------
    // reset values and source select codes
    // ------------------------------------------------------------
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  ROUTING_RST  = 8'h00;
    localparam logic [7:0]  CYCLES_RST   = 8'h00;
    localparam logic [1:0]  SRC_EXT      = 2'h0;
    localparam logic [1:0]  SRC_NONE     = 2'h1;
    localparam logic [1:0]  SRC_OSC      = 2'h2;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_ONE      = 4'h1;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;
    localparam logic [23:0] UPPER_ZERO   = 24'h00_0000;
    localparam logic [4:0]  UNUSED_ZERO  = 5'h00;

endpackage : ch3dc_pkg

// ==== design/ch3dc_top.sv ====
// Purpose: channel three divider, its apb registers and output routing
// Assumes: divider input clock arrives as a level sampled on clk; inputs synchronous to clk
// Notes:   apb access takes three cycles, one of them a wait state; outputs are registered levels
`timescale 1ns/1ps
`default_nettype none

module ch3dc_top
    import ch3dc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              chip_sync,
    input  wire logic              div_in_level,
    input  wire ch3dc_source_s     source,
    output logic                   group_three_output_a,
    output logic                   group_three_output_b,
    output logic                   group_three_output_c,
    output logic                   duty_cycle_correction_en,
    output logic                   divider_powered_down
);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    ch3dc_mode_s    mode_q;
    ch3dc_routing_s routing_q;
    ch3dc_cycles_s  cycles_q;
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic           div_q;
    logic [3:0]     cnt_q;
    logic [3:0]     phase_cnt_q;
    logic           in_prev_q;
    logic           out_q;
    logic           dcc_q;
    logic           div_pd_q;

    logic           access;
    logic           wr_take;
    logic           tick;
    logic           forced;
    logic           forced_level;
    logic           running;
    logic           sync_take;
    logic           route_osc;
    logic           route_ext;
    logic           out_d;
    logic [31:0]    rdata_d;
    logic           err_d;

    assign access    = psel && penable;
    assign wr_take   = access && pready_q && pwrite && pstrb[0];
    assign tick      = div_in_level && !in_prev_q;
    // static output only with ignore-sync held together with force
    assign forced    = mode_q.ignore_sync && mode_q.force_high && !mode_q.bypass;
    assign forced_level = mode_q.force_high ? mode_q.start_high : 1'b0;
    assign running   = !routing_q.power_down && !mode_q.bypass && !forced;
    assign sync_take = chip_sync && !mode_q.ignore_sync;
    assign route_osc = routing_q.direct && (source.src_sel == SRC_OSC);
    assign route_ext = routing_q.direct && (source.src_sel == SRC_EXT);

    // ------------------------------------------------------------
    // apb read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = RDATA_ZERO;
        err_d   = 1'b0;
        unique case (paddr)
            ADDR_CYCLES:  rdata_d = {UPPER_ZERO, cycles_q};
            ADDR_MODE:    rdata_d = {UPPER_ZERO, mode_q};
            ADDR_ROUTING: rdata_d = {UPPER_ZERO, UNUSED_ZERO, routing_q.power_down,
                                     routing_q.direct, routing_q.dcc_disable};
            ADDR_STATUS:  rdata_d = {UPPER_ZERO, 4'h0, (phase_cnt_q != CNT_ZERO),
                                     div_pd_q, dcc_q, div_q};
            default:      err_d   = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // apb handshake: one wait state, answer registered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= RDATA_ZERO;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? RDATA_ZERO : rdata_d;
            pslverr_q <= err_d || (pwrite && paddr == ADDR_STATUS);
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= ch3dc_mode_s'(MODE_RST);
            routing_q <= ch3dc_routing_s'(ROUTING_RST);
            cycles_q  <= ch3dc_cycles_s'(CYCLES_RST);
        end else if (wr_take) begin
            if (paddr == ADDR_MODE) begin
                mode_q <= ch3dc_mode_s'(pwdata[7:0]);
            end
            if (paddr == ADDR_ROUTING) begin
                routing_q <= {UNUSED_ZERO, pwdata[2:0]};
            end
            if (paddr == ADDR_CYCLES) begin
                cycles_q <= ch3dc_cycles_s'(pwdata[7:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // divider input edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_prev_q <= 1'b0;
        end else begin
            in_prev_q <= div_in_level;
        end
    end

    // ------------------------------------------------------------
    // divider core: phase delay, then low and high counts
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q       <= 1'b0;
            cnt_q       <= CNT_ZERO;
            phase_cnt_q <= CNT_ZERO;
        end else if (routing_q.power_down || mode_q.bypass) begin
            // divider powered down, restart cleanly when it returns
            div_q       <= mode_q.start_high;
            cnt_q       <= mode_q.start_high ? cycles_q.high : cycles_q.low;
            phase_cnt_q <= mode_q.phase;
        end else if (sync_take) begin
            div_q       <= mode_q.start_high;
            cnt_q       <= mode_q.start_high ? cycles_q.high : cycles_q.low;
            phase_cnt_q <= mode_q.phase;
        end else if (running && tick) begin
            if (phase_cnt_q != CNT_ZERO) begin
                phase_cnt_q <= phase_cnt_q - CNT_ONE;
            end else if (cnt_q == CNT_ZERO) begin
                div_q <= !div_q;
                cnt_q <= div_q ? cycles_q.low : cycles_q.high;
            end else begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // output routing
    // ------------------------------------------------------------
    always_comb begin
        if (routing_q.power_down) begin
            out_d = 1'b0;
        end else if (route_osc) begin
            out_d = source.osc_level;
        end else if (route_ext) begin
            out_d = source.ext_level;
        end else if (mode_q.bypass) begin
            out_d = div_in_level;
        end else if (forced) begin
            out_d = forced_level;
        end else begin
            out_d = div_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q    <= 1'b0;
            dcc_q    <= 1'b0;
            div_pd_q <= 1'b0;
        end else begin
            out_q    <= out_d;
            dcc_q    <= !routing_q.dcc_disable && !mode_q.bypass
                        && !routing_q.power_down;
            div_pd_q <= mode_q.bypass || routing_q.power_down;
        end
    end

    assign prdata                   = prdata_q;
    assign pready                   = pready_q;
    assign pslverr                  = pslverr_q;
    assign group_three_output_a     = out_q;
    assign group_three_output_b     = out_q;
    assign group_three_output_c     = out_q;
    assign duty_cycle_correction_en = dcc_q;
    assign divider_powered_down     = div_pd_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PD_SAFE: assert property (
        routing_q.power_down |=> !group_three_output_a && !group_three_output_b
                                 && !group_three_output_c)
        else $error("outputs not low while channel powered down");

    AST_BYPASS_PASS: assert property (
        !routing_q.power_down && !routing_q.direct && mode_q.bypass
        |=> group_three_output_a == $past(div_in_level))
        else $error("bypass did not pass divider input");

    AST_BYPASS_NOFORCE: assert property (
        !routing_q.power_down && !routing_q.direct && mode_q.bypass
        && mode_q.ignore_sync && mode_q.force_high && !div_in_level
        |=> !group_three_output_a)
        else $error("force acted while bypassed");

    AST_FORCE_LEVEL: assert property (
        !routing_q.power_down && !routing_q.direct && !mode_q.bypass
        && mode_q.ignore_sync && mode_q.force_high
        |=> group_three_output_b == $past(mode_q.start_high))
        else $error("forced level wrong");

    AST_SYNC_IGNORED: assert property (
        chip_sync && mode_q.ignore_sync && !tick && !wr_take
        && !routing_q.power_down && !mode_q.bypass
        |=> $stable(div_q) && $stable(phase_cnt_q) && $stable(cnt_q))
        else $error("ignored sync changed divider");

    AST_SYNC_START: assert property (
        chip_sync && !mode_q.ignore_sync && !routing_q.power_down && !mode_q.bypass
        |=> div_q == $past(mode_q.start_high) && phase_cnt_q == $past(mode_q.phase))
        else $error("sync did not restart divider");

    AST_DIRECT_OSC: assert property (
        !routing_q.power_down && routing_q.direct && source.src_sel == SRC_OSC
        |=> group_three_output_c == $past(source.osc_level))
        else $error("oscillator not routed to outputs");

    AST_DIRECT_EXT: assert property (
        !routing_q.power_down && routing_q.direct && source.src_sel == SRC_EXT
        |=> group_three_output_c == $past(source.ext_level))
        else $error("external clock not routed to outputs");

    AST_SRC_NONE: assert property (
        !routing_q.power_down && routing_q.direct && source.src_sel == SRC_NONE
        && !mode_q.bypass && !forced
        |=> group_three_output_a == $past(div_q))
        else $error("direct bit acted with select 01b");

    AST_DCC: assert property (
        $past(rst_n) |-> duty_cycle_correction_en == $past(!routing_q.dcc_disable
                                                    && !mode_q.bypass && !routing_q.power_down))
        else $error("correction enable wrong");

    AST_LOW_LEN: assert property (
        running && tick && !sync_take && phase_cnt_q == CNT_ZERO
        && cnt_q == CNT_ZERO && div_q
        |=> !div_q && cnt_q == $past(cycles_q.low))
        else $error("low count not loaded");

    AST_HIGH_LEN: assert property (
        running && tick && !sync_take && phase_cnt_q == CNT_ZERO
        && cnt_q == CNT_ZERO && !div_q
        |=> div_q && cnt_q == $past(cycles_q.high))
        else $error("high count not loaded");

    AST_PHASE_HOLD: assert property (
        running && tick && !sync_take && phase_cnt_q != CNT_ZERO
        |=> phase_cnt_q == $past(phase_cnt_q) - CNT_ONE && $stable(div_q))
        else $error("phase delay not counted");

    AST_PD_FLAG: assert property (
        $past(rst_n)
        |-> divider_powered_down == $past(mode_q.bypass || routing_q.power_down))
        else $error("divider power-down flag wrong");

    AST_DIV_FROZEN: assert property (
        routing_q.power_down || mode_q.bypass
        |=> div_q == $past(mode_q.start_high) && phase_cnt_q == $past(mode_q.phase))
        else $error("divider not held while powered down");

    AST_FORCE_FROZEN: assert property (
        forced && !routing_q.power_down
        |=> $stable(div_q) && $stable(cnt_q) && $stable(phase_cnt_q))
        else $error("divider moved while output forced");

    AST_MID_COUNT: assert property (
        running && tick && !sync_take && phase_cnt_q == CNT_ZERO && cnt_q != CNT_ZERO
        |=> cnt_q == $past(cnt_q) - CNT_ONE && $stable(div_q))
        else $error("half period count not stepped");

    AST_IDLE_HOLD: assert property (
        !tick && !chip_sync && !routing_q.power_down && !mode_q.bypass
        |=> $stable(div_q) && $stable(cnt_q) && $stable(phase_cnt_q))
        else $error("divider moved without an input edge");

    AST_DIV_PATH: assert property (
        !routing_q.power_down && !routing_q.direct && !mode_q.bypass && !forced
        |=> group_three_output_a == $past(div_q))
        else $error("divider not feeding outputs");

    AST_SYNC_CNT: assert property (
        sync_take && !routing_q.power_down && !mode_q.bypass
        |=> cnt_q == ($past(mode_q.start_high) ? $past(cycles_q.high) : $past(cycles_q.low)))
        else $error("sync did not load half period count");

    COV_SYNC: cover property (sync_take ##1 running && tick);
    COV_FORCE: cover property (forced && !routing_q.direct);
    COV_OSC: cover property (route_osc && !routing_q.power_down);
    COV_TOGGLE: cover property (!div_q ##1 div_q ##[1:40] !div_q);

endmodule : ch3dc_top

`default_nettype wire

// ==== verification/tb_channel_three_divider_control.sv ====
// Purpose: self-checking bench for the channel three divider control block
// Assumes: apb answer after one wait state; outputs settle within three clocks
// Notes:   divider input edges are slow pulses on div_in_level
`timescale 1ns/1ps
`default_nettype none

module tb_channel_three_divider_control
    import ch3dc_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              chip_sync;
    logic              div_in_level;
    ch3dc_source_s     source;
    logic              oa;
    logic              ob;
    logic              oc;
    logic              dcc_en;
    logic              pd;
    int                n_mismatch;
    int                checks_done;
    int                cyc;
    logic [15:0]       cfg [3];
    logic [31:0]       r;
    logic              e;

    ch3dc_top u_ch3dc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_sync(chip_sync),
        .div_in_level(div_in_level), .source(source), .group_three_output_a(oa),
        .group_three_output_b(ob), .group_three_output_c(oc),
        .duty_cycle_correction_en(dcc_en), .divider_powered_down(pd));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic flg(input string n, input logic x, input logic g);
        chk(n, {31'h0000_0000, x}, {31'h0000_0000, g});
    endtask : flg

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'h1, a, {UPPER_ZERO, d}, rd, er);
    endtask : wr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] rd;
        logic        er;
        apb(1'h0, a, RDATA_ZERO, rd, er);
        chk("prdata", x, rd);
        flg("pslverr", xe, er);
    endtask : rdc

    task automatic outc(input logic x);
        repeat (3) @(posedge clk);
        chk("outputs", {29'h0000_0000, {3{x}}}, {29'h0000_0000, oa, ob, oc});
    endtask : outc

    task automatic pulse_in();
        div_in_level <= 1'h1;
        repeat (3) @(posedge clk);
        div_in_level <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : pulse_in

    task automatic sync();
        chip_sync <= 1'h1;
        @(posedge clk);
        chip_sync <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : sync

    // level after n input edges since sync
    function automatic logic dmodel(input logic [7:0] cy, input logic [7:0] md, input int n);
        logic l;
        int   p;
        int   rem;
        l = md[4];
        p = md[3:0];
        rem = l ? cy[3:0] + 1 : cy[7:4] + 1;
        for (int i = 0; i < n; i++) begin
            if (p > 0) begin
                p--;
            end else begin
                rem--;
                if (rem == 0) begin
                    l = ~l;
                    rem = l ? cy[3:0] + 1 : cy[7:4] + 1;
                end
            end
        end
        return l;
    endfunction : dmodel

    // ------------------------------------------------------------
    // clock, reset, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        {psel, penable, pwrite, chip_sync, div_in_level} = 5'h00;
        paddr = '0;
        pwdata = RDATA_ZERO;
        pstrb = 4'hf;
        source = {1'h0, 1'h0, SRC_NONE};
        n_mismatch = 0;
        checks_done = 0;
        cyc = 0;
        cfg = '{16'h2100, 16'h1012, 16'h0315};
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rdc(ADDR_CYCLES, RDATA_ZERO, 1'h0);
        rdc(ADDR_MODE, RDATA_ZERO, 1'h0);
        rdc(ADDR_ROUTING, RDATA_ZERO, 1'h0);
        rdc(ADDR_STATUS, 32'h0000_0002, 1'h0);
        flg("dcc_en", 1'h1, dcc_en);
        flg("powered_down", 1'h0, pd);
        rdc(12'h000, RDATA_ZERO, 1'h1);
        apb(1'h1, ADDR_STATUS, 32'h0000_00ff, r, e);
        flg("status_write_err", 1'h1, e);
        wr(ADDR_MODE, 8'ha5);
        rdc(ADDR_MODE, 32'h0000_00a5, 1'h0);
        wr(ADDR_ROUTING, 8'hff);
        rdc(ADDR_ROUTING, 32'h0000_0007, 1'h0);
        wr(ADDR_CYCLES, 8'h3c);
        pstrb <= 4'h0;
        wr(ADDR_CYCLES, 8'h11);
        pstrb <= 4'hf;
        rdc(ADDR_CYCLES, 32'h0000_003c, 1'h0);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_ROUTING, 8'h00);
        $display("test registers done");
        foreach (cfg[c]) begin
            wr(ADDR_CYCLES, cfg[c][15:8]);
            wr(ADDR_MODE, cfg[c][7:0]);
            sync();
            outc(cfg[c][4]);
            for (int k = 1; k <= 12; k++) begin
                pulse_in();
                outc(dmodel(cfg[c][15:8], cfg[c][7:0], k));
            end
        end
        $display("test divider done");
        wr(ADDR_CYCLES, 8'h00);
        wr(ADDR_MODE, 8'h00);
        sync();
        pulse_in();
        outc(1'h1);
        wr(ADDR_MODE, 8'h40);
        sync();
        outc(1'h1);
        wr(ADDR_MODE, 8'h00);
        sync();
        outc(1'h0);
        $display("test sync done");
        wr(ADDR_MODE, 8'h70);
        outc(1'h1);
        pulse_in();
        outc(1'h1);
        wr(ADDR_MODE, 8'h60);
        pulse_in();
        outc(1'h0);
        wr(ADDR_MODE, 8'hf0);
        @(posedge clk);
        flg("powered_down", 1'h1, pd);
        div_in_level <= 1'h1;
        outc(1'h1);
        div_in_level <= 1'h0;
        outc(1'h0);
        $display("test force_bypass done");
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_ROUTING, 8'h04);
        @(posedge clk);
        flg("powered_down", 1'h1, pd);
        pulse_in();
        outc(1'h0);
        wr(ADDR_ROUTING, 8'h01);
        @(posedge clk);
        flg("dcc_en", 1'h0, dcc_en);
        wr(ADDR_ROUTING, 8'h02);
        @(posedge clk);
        flg("dcc_en", 1'h1, dcc_en);
        wr(ADDR_MODE, 8'h00);
        sync();
        source <= {1'h1, 1'h0, SRC_OSC};
        outc(1'h1);
        source <= {1'h0, 1'h1, SRC_OSC};
        outc(1'h0);
        source <= {1'h0, 1'h1, SRC_EXT};
        outc(1'h1);
        source <= {1'h1, 1'h0, SRC_EXT};
        outc(1'h0);
        source <= {1'h1, 1'h1, SRC_NONE};
        outc(1'h0);
        $display("test routing done");
        results();
    end

endmodule : tb_channel_three_divider_control

`default_nettype wire
